// *** bsd_pkg.sv ***
// Address map, boot codes and state types for the boot select and decode block
package bsd_pkg;

  localparam int          DEC_NUM  = 36;
  localparam int          PIN_W    = 4;
  localparam logic [31:0] ROM_BASE = 32'h0010_0000;
  localparam logic [31:0] L2_BASE  = 32'h0080_0000;
  localparam logic [31:0] CS3_BASE = 32'hb000_0000;

  localparam logic [3:0] BOOT_NONE     = 4'h0;
  localparam logic [3:0] BOOT_HOST_HPI = 4'h1;
  localparam logic [3:0] BOOT_EMIF_ROM = 4'h4;
  localparam logic [3:0] BOOT_I2C_MST  = 4'h5;
  localparam logic [3:0] BOOT_I2C_SLV  = 4'h6;
  localparam logic [3:0] BOOT_HOST_PCI = 4'h7;

  localparam logic [3:0] MODE_RST = 4'h0;

  typedef enum logic [5:0] {
    TGT_NONE, TGT_ROM, TGT_L2, TGT_L1P, TGT_L1D, TGT_CORE,
    TGT_HOST, TGT_SP0_REG, TGT_SP1_REG, TGT_TMR0, TGT_TMR1,
    TGT_MCLK, TGT_SCLK, TGT_DMA_CC, TGT_DMA_TC0, TGT_DMA_TC1,
    TGT_DMA_TC2, TGT_DMA_TC3, TGT_CHIP, TGT_DEV_STATE, TGT_GPIO,
    TGT_I2C, TGT_PCI_CTRL, TGT_ETH_CTRL, TGT_ETH_MOD, TGT_MDIO,
    TGT_ETH_DESC, TGT_SP0_DATA, TGT_SP1_DATA, TGT_PCI_MEM,
    TGT_EXT_CFG, TGT_DDR_CFG, TGT_CS2, TGT_CS3, TGT_CS4, TGT_CS5,
    TGT_DDR_CS0
  } bsd_target_e;

  typedef enum logic [2:0] {
    ST_SAMPLE, ST_DECIDE, ST_HW_WAIT, ST_SW_BOOT, ST_RUN
  } bsd_state_e;

  // First and last byte of each window, in enum order after TGT_NONE
  localparam logic [63:0] DEC_MAP [DEC_NUM] = '{
    {ROM_BASE,      32'h0010_7fff},
    {L2_BASE,       32'h008f_ffff},
    {32'h00e0_0000, 32'h00e0_7fff},
    {32'h00f0_0000, 32'h00f0_7fff},
    {32'h0180_0000, 32'h01bf_ffff},
    {32'h0288_0000, 32'h028b_ffff},
    {32'h028c_0000, 32'h028f_ffff},
    {32'h0290_0000, 32'h0293_ffff},
    {32'h0294_0000, 32'h0297_ffff},
    {32'h0298_0000, 32'h0299_ffff},
    {32'h029a_0000, 32'h029a_01ff},
    {32'h029c_0000, 32'h029c_01ff},
    {32'h02a0_0000, 32'h02a0_7fff},
    {32'h02a2_0000, 32'h02a2_7fff},
    {32'h02a2_8000, 32'h02a2_ffff},
    {32'h02a3_0000, 32'h02a3_7fff},
    {32'h02a3_8000, 32'h02a3_ffff},
    {32'h02a8_0000, 32'h02ab_ffff},
    {32'h02ac_0000, 32'h02af_ffff},
    {32'h02b0_0000, 32'h02b0_3fff},
    {32'h02b0_4000, 32'h02b3_ffff},
    {32'h02c0_0000, 32'h02c3_ffff},
    {32'h02c8_0000, 32'h02c8_0fff},
    {32'h02c8_1000, 32'h02c8_17ff},
    {32'h02c8_1800, 32'h02c8_1fff},
    {32'h02c8_2000, 32'h02c8_3fff},
    {32'h3000_0000, 32'h3000_00ff},
    {32'h3400_0000, 32'h3400_00ff},
    {32'h4000_0000, 32'h4fff_ffff},
    {32'h7000_0000, 32'h77ff_ffff},
    {32'h7800_0000, 32'h7fff_ffff},
    {32'ha000_0000, 32'ha07f_ffff},
    {CS3_BASE,      32'hb07f_ffff},
    {32'hc000_0000, 32'hc07f_ffff},
    {32'hd000_0000, 32'hd07f_ffff},
    {32'he000_0000, 32'hefff_ffff}
  };

endpackage : bsd_pkg

// *** bsd_pin_sync.sv ***
// Three-stage pin synchroniser with agreement flag
`timescale 1ns/1ps
module bsd_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync,
  output logic              pin_stable
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Free running so the pins are captured while reset is held
  always_ff @(posedge clk) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  assign pin_sync   = s3_q;
  assign pin_stable = (s2_q == s3_q);

endmodule : bsd_pin_sync

// *** bsd_boot_classify.sv ***
// Boot code classifier: hardware or software boot and start address
`timescale 1ns/1ps
module bsd_boot_classify (
  input  wire logic [3:0]  mode,
  output logic             is_hw,
  output logic             wait_host,
  output logic [31:0]      start_addr
);

  always_comb begin
    is_hw      = 1'b0;
    wait_host  = 1'b0;
    start_addr = bsd_pkg::ROM_BASE;
    case (mode)
      bsd_pkg::BOOT_NONE: begin
        is_hw      = 1'b1;
        start_addr = bsd_pkg::L2_BASE;
      end
      bsd_pkg::BOOT_HOST_HPI: begin
        is_hw      = 1'b1;
        wait_host  = 1'b1;
        start_addr = bsd_pkg::L2_BASE;
      end
      bsd_pkg::BOOT_EMIF_ROM: begin
        is_hw      = 1'b1;
        start_addr = bsd_pkg::CS3_BASE;
      end
      default: begin
        is_hw      = 1'b0;
        start_addr = bsd_pkg::ROM_BASE;
      end
    endcase
  end

endmodule : bsd_boot_classify

// *** bsd_top.sv ***
// Boot start logic and device address decoder
// What this block does
// - Boot starts by itself after every reset
// - Boot mode taken from four pins at reset
// - Software boot runs ROM loader at ROM base
// - Hardware boot runs without processor instructions
// - ROM window decodes 32K bytes
// - Second-level RAM decodes 1M bytes
// - First-level program and data SRAM windows
// - Core-cluster register window of 4M bytes
// - Host port, serial ports and timer windows
// - Main and secondary clock controller windows
// - DMA channel and four transfer controllers
// - Chip, device state, GPIO and I2C windows
// - PCI control and Ethernet windows
// - Serial port data windows of 256 bytes
// - PCI external memory space of 256M
// - External memory and DDR configuration windows
// - Chip-select spaces two to five, 8M each
// - DDR chip-select zero space of 256M
// - Chip-selects zero and one do not exist
`timescale 1ns/1ps
module bsd_top (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [3:0]           boot_select_pins,
  input  wire logic                 host_boot_done,
  input  wire logic                 bootloader_done,
  input  wire logic                 acc_req,
  input  wire logic [31:0]          acc_addr,
  output bsd_pkg::bsd_target_e      acc_target_q,
  output logic                      acc_ack_q,
  output logic                      acc_reserved_q,
  output logic [3:0]                boot_mode_q,
  output logic                      boot_hw_q,
  output logic                      boot_done_q,
  output logic                      cpu_release_q,
  output logic [31:0]               cpu_start_addr_q,
  output bsd_pkg::bsd_target_e      start_target_q,
  output logic                      rom_clock_limit_q
);

  bsd_pkg::bsd_state_e state_q;
  bsd_pkg::bsd_state_e state_d;
  logic [3:0]          pins_sync;
  logic                pins_stable;
  logic                cls_hw;
  logic                cls_wait;
  logic [31:0]         cls_addr;
  logic                rel_seen_q;
  bsd_pkg::bsd_target_e acc_dec;

  // Range lookup over the address map
  function automatic bsd_pkg::bsd_target_e decode(input logic [31:0] a);
    bsd_pkg::bsd_target_e t;
    t = bsd_pkg::TGT_NONE;
    for (int i = 0; i < bsd_pkg::DEC_NUM; i++) begin
      if (a >= bsd_pkg::DEC_MAP[i][63:32] && a <= bsd_pkg::DEC_MAP[i][31:0]) begin
        t = bsd_pkg::bsd_target_e'(6'(i + 1));
      end
    end
    return t;
  endfunction : decode

  bsd_pin_sync #(
    .W (bsd_pkg::PIN_W)
  ) u_sync (
    .clk        (clk),
    .pin_in     (boot_select_pins),
    .pin_sync   (pins_sync),
    .pin_stable (pins_stable)
  );

  bsd_boot_classify u_cls (
    .mode       (boot_mode_q),
    .is_hw      (cls_hw),
    .wait_host  (cls_wait),
    .start_addr (cls_addr)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      bsd_pkg::ST_SAMPLE: begin
        if (pins_stable) begin
          state_d = bsd_pkg::ST_DECIDE;
        end
      end
      bsd_pkg::ST_DECIDE: begin
        if (!cls_hw) begin
          state_d = bsd_pkg::ST_SW_BOOT;
        end else if (cls_wait) begin
          state_d = bsd_pkg::ST_HW_WAIT;
        end else begin
          state_d = bsd_pkg::ST_RUN;
        end
      end
      bsd_pkg::ST_HW_WAIT: begin
        if (host_boot_done) begin
          state_d = bsd_pkg::ST_RUN;
        end
      end
      bsd_pkg::ST_SW_BOOT: begin
        if (bootloader_done) begin
          state_d = bsd_pkg::ST_RUN;
        end
      end
      bsd_pkg::ST_RUN: begin
        state_d = bsd_pkg::ST_RUN;
      end
      default: begin
        state_d = bsd_pkg::ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= bsd_pkg::ST_SAMPLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_mode_q <= bsd_pkg::MODE_RST;
    end else if (state_q == bsd_pkg::ST_SAMPLE && pins_stable) begin
      boot_mode_q <= pins_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_hw_q <= 1'b0;
    end else if (state_q == bsd_pkg::ST_DECIDE) begin
      boot_hw_q <= cls_hw;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_release_q    <= 1'b0;
      cpu_start_addr_q <= bsd_pkg::ROM_BASE;
      start_target_q   <= bsd_pkg::TGT_NONE;
    end else begin
      if (state_q == bsd_pkg::ST_DECIDE) begin
        cpu_start_addr_q <= cls_addr;
        start_target_q   <= decode(cls_addr);
      end
      if (state_q == bsd_pkg::ST_DECIDE && !(cls_hw && cls_wait)) begin
        cpu_release_q <= 1'b1;
      end else if (state_q == bsd_pkg::ST_HW_WAIT && host_boot_done) begin
        cpu_release_q <= 1'b1;
      end
    end
  end

  // Flags clock limit during loader run
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rom_clock_limit_q <= 1'b0;
    end else if (state_q == bsd_pkg::ST_DECIDE) begin
      rom_clock_limit_q <= !cls_hw;
    end else if (state_q == bsd_pkg::ST_SW_BOOT && bootloader_done) begin
      rom_clock_limit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_done_q <= 1'b0;
    end else if (state_d == bsd_pkg::ST_RUN) begin
      boot_done_q <= 1'b1;
    end
  end

  assign acc_dec = decode(acc_addr);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_ack_q      <= 1'b0;
      acc_target_q   <= bsd_pkg::TGT_NONE;
      acc_reserved_q <= 1'b0;
    end else begin
      acc_ack_q <= acc_req;
      if (acc_req) begin
        acc_target_q   <= acc_dec;
        acc_reserved_q <= (acc_dec == bsd_pkg::TGT_NONE);
      end
    end
  end

  // Release marker for reset checks
  always_ff @(posedge clk) begin
    rel_seen_q <= rst_b;
  end

  sequence s_release;
    rst_b && !rel_seen_q;
  endsequence

  sequence s_sampled;
    state_q == bsd_pkg::ST_SAMPLE && pins_stable;
  endsequence

  sequence s_decided;
    state_q == bsd_pkg::ST_DECIDE;
  endsequence

  auto_start_a : assert property (
    @(posedge clk) s_release |-> ##[1:8] (cpu_release_q || state_q == bsd_pkg::ST_HW_WAIT))
    else $error("boot did not start after reset");

  mode_latch_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    s_sampled |=> (boot_mode_q == $past(pins_sync)) ##0 s_decided)
    else $error("boot mode not latched from pins");

  sw_rom_start_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(cpu_release_q) && !boot_hw_q |-> cpu_start_addr_q == bsd_pkg::ROM_BASE
      && start_target_q == bsd_pkg::TGT_ROM)
    else $error("software boot not started at ROM");

  hw_hold_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    state_q == bsd_pkg::ST_HW_WAIT && !host_boot_done |=> !cpu_release_q && !rom_clock_limit_q)
    else $error("processor released during host load");

  rom_limit_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    state_q == bsd_pkg::ST_SW_BOOT |-> rom_clock_limit_q && !boot_hw_q)
    else $error("clock limit flag dropped during loader");

  rom_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:15] == 17'h0_0020
      |=> acc_ack_q && acc_target_q == bsd_pkg::TGT_ROM)
    else $error("ROM window misdecoded");

  l2_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:20] == 12'h008 |=> acc_target_q == bsd_pkg::TGT_L2)
    else $error("second-level RAM window misdecoded");

  ext_space_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[27:23] == 5'h00 && acc_addr[31:28] >= 4'ha && acc_addr[31:28] <= 4'hd
      |=> acc_target_q >= bsd_pkg::TGT_CS2 && acc_target_q <= bsd_pkg::TGT_CS5)
    else $error("chip-select space misdecoded");

  no_low_cs_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && (acc_addr[31:28] == 4'h8 || acc_addr[31:28] == 4'h9) |=> acc_reserved_q)
    else $error("absent chip-select decoded");

  reserved_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_ack_q |-> (acc_reserved_q == (acc_target_q == bsd_pkg::TGT_NONE)))
    else $error("reserved flag disagrees with target");

  ddr_space_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:28] == 4'he |=> acc_target_q == bsd_pkg::TGT_DDR_CS0)
    else $error("DDR space misdecoded");

  l1p_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:15] == 17'h0_01c0 |=> acc_target_q == bsd_pkg::TGT_L1P)
    else $error("first-level program window misdecoded");

  l1d_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:15] == 17'h0_01e0 |=> acc_target_q == bsd_pkg::TGT_L1D)
    else $error("first-level data window misdecoded");

  core_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:22] == 10'h006 |=> acc_target_q == bsd_pkg::TGT_CORE)
    else $error("core register window misdecoded");

  host_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:18] == 14'h00a2 |=> acc_target_q == bsd_pkg::TGT_HOST)
    else $error("host port window misdecoded");

  clk_ctrl_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:9] == 23'h01_4d00 |=> acc_target_q == bsd_pkg::TGT_MCLK)
    else $error("main clock controller window misdecoded");

  dma_tc3_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:15] == 17'h0_0547 |=> acc_target_q == bsd_pkg::TGT_DMA_TC3)
    else $error("last transfer controller window misdecoded");

  gpio_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:14] == 18'h0_0ac0 |=> acc_target_q == bsd_pkg::TGT_GPIO)
    else $error("GPIO window misdecoded");

  mdio_window_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:11] == 21'h00_5903 |=> acc_target_q == bsd_pkg::TGT_MDIO)
    else $error("MDIO window misdecoded");

  serial_data_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:8] == 24'h30_0000 |=> acc_target_q == bsd_pkg::TGT_SP0_DATA)
    else $error("serial data window misdecoded");

  pci_mem_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:28] == 4'h4 |=> acc_target_q == bsd_pkg::TGT_PCI_MEM)
    else $error("PCI memory space misdecoded");

  ext_cfg_a : assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_req && acc_addr[31:27] == 5'h0e |=> acc_target_q == bsd_pkg::TGT_EXT_CFG)
    else $error("external memory configuration window misdecoded");

endmodule : bsd_top

// *** bsd_bus_master.sv ***
// Bus master model issuing addressed accesses to the decoder
`timescale 1ns/1ps
module bsd_bus_master (
  input  wire logic        clk,
  output logic             acc_req,
  output logic [31:0]      acc_addr
);

  initial begin
    acc_req  = 1'b0;
    acc_addr = 32'h0000_0000;
  end

  task automatic issue(input logic [31:0] a);
    @(negedge clk);
    acc_req  <= 1'b1;
    acc_addr <= a;
  endtask : issue

  // Released bus shows inverted address
  task automatic idle();
    @(negedge clk);
    acc_req  <= 1'b0;
    acc_addr <= ~acc_addr;
  endtask : idle

endmodule : bsd_bus_master

// *** boot_select_address_decode_tb.sv ***
// Self-checking testbench for the boot select and decode block
`timescale 1ns/1ps
module boot_select_address_decode_tb;

  localparam int N = 53;
  localparam logic [31:0] ADR [N] = '{
    32'h0010_0000, 32'h0010_7fff, 32'h0010_8000, 32'h000f_ffff,
    32'h0080_0000, 32'h008f_ffff, 32'h0090_0000, 32'h00e0_7fff, 32'h00f0_0000,
    32'h0180_0000, 32'h01bf_ffff, 32'h01c0_0000,
    32'h0288_0000, 32'h028c_0000, 32'h0293_ffff, 32'h0294_0000, 32'h0299_ffff,
    32'h029a_01ff, 32'h029a_0200, 32'h029c_0000,
    32'h02a0_7fff, 32'h02a2_0000, 32'h02a2_8000, 32'h02a3_0000, 32'h02a3_ffff, 32'h02a4_0000,
    32'h02a8_0000, 32'h02af_ffff, 32'h02b0_3fff, 32'h02b0_4000,
    32'h02c0_0000, 32'h02c8_0fff, 32'h02c8_1000, 32'h02c8_1800, 32'h02c8_3fff, 32'h02c8_4000,
    32'h3000_00ff, 32'h3000_0100, 32'h3400_0000,
    32'h4fff_ffff, 32'h5000_0000,
    32'h7000_0000, 32'h7fff_ffff,
    32'ha07f_ffff, 32'ha080_0000, 32'hb000_0000, 32'hc07f_ffff, 32'hd000_0000,
    32'h8000_0000, 32'h9000_0000,
    32'he000_0000, 32'hefff_ffff, 32'hffff_ffff
  };
  // Target ordinals in enum order, zero for reserved
  localparam int TN [N] = '{
    1, 1, 0, 0, 2, 2, 0, 3, 4, 5, 5, 0, 6, 7, 8, 9, 10, 11, 0, 12,
    13, 14, 15, 16, 17, 0, 18, 19, 20, 21, 22, 23, 24, 25, 26, 0,
    27, 0, 28, 29, 0, 30, 31, 32, 0, 33, 34, 35, 0, 0, 36, 36, 0
  };

  logic                 clk;
  logic                 rst_b;
  logic [3:0]           pins;
  logic                 host_done;
  logic                 loader_done;
  logic                 acc_req;
  logic [31:0]          acc_addr;
  bsd_pkg::bsd_target_e acc_target_q;
  logic                 acc_ack_q;
  logic                 acc_reserved_q;
  logic [3:0]           boot_mode_q;
  logic                 boot_hw_q;
  logic                 boot_done_q;
  logic                 cpu_release_q;
  logic [31:0]          cpu_start_addr_q;
  bsd_pkg::bsd_target_e start_target_q;
  logic                 rom_clock_limit_q;
  int                   fail_count;
  int                   n_checks;

  bsd_top dut (
    .clk(clk), .rst_b(rst_b), .boot_select_pins(pins), .host_boot_done(host_done),
    .bootloader_done(loader_done), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_target_q(acc_target_q), .acc_ack_q(acc_ack_q), .acc_reserved_q(acc_reserved_q),
    .boot_mode_q(boot_mode_q), .boot_hw_q(boot_hw_q), .boot_done_q(boot_done_q),
    .cpu_release_q(cpu_release_q), .cpu_start_addr_q(cpu_start_addr_q),
    .start_target_q(start_target_q), .rom_clock_limit_q(rom_clock_limit_q)
  );

  bsd_bus_master bm (.clk(clk), .acc_req(acc_req), .acc_addr(acc_addr));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_tgt(input bsd_pkg::bsd_target_e got, input bsd_pkg::bsd_target_e exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t target %0d expected %0d", $time, got, exp);
    end
  endtask : chk_tgt

  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic boot_case(input logic [3:0] code);
    logic                 hw;
    logic                 wt;
    logic [31:0]          ea;
    bsd_pkg::bsd_target_e et;
    hw = (code == 4'h0) || (code == 4'h1) || (code == 4'h4);
    wt = (code == 4'h1);
    ea = (code == 4'h4) ? 32'hb000_0000 : (hw ? 32'h0080_0000 : 32'h0010_0000);
    et = (code == 4'h4) ? bsd_pkg::TGT_CS3 : (hw ? bsd_pkg::TGT_L2 : bsd_pkg::TGT_ROM);
    @(negedge clk);
    pins = code;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    chk_val(cpu_release_q, 32'h0);
    chk_val(cpu_start_addr_q, 32'h0010_0000);
    rst_b = 1'b1;
    @(negedge clk);
    pins = ~code;
    chk_val(boot_mode_q, code);
    @(negedge clk);
    chk_val(boot_hw_q, hw);
    chk_val(cpu_start_addr_q, ea);
    chk_tgt(start_target_q, et);
    chk_val(cpu_release_q, !wt);
    chk_val(boot_done_q, hw && !wt);
    chk_val(rom_clock_limit_q, !hw);
    host_done = !wt;
    loader_done = wt;
    @(negedge clk);
    host_done = 1'b0;
    loader_done = 1'b0;
    chk_val(boot_done_q, hw && !wt);
    chk_val(cpu_release_q, !wt);
    chk_val(boot_mode_q, code);
    host_done = wt;
    loader_done = !hw;
    @(negedge clk);
    host_done = 1'b0;
    loader_done = 1'b0;
    chk_val(boot_done_q, 32'h1);
    chk_val(cpu_release_q, 32'h1);
    chk_val(rom_clock_limit_q, 32'h0);
  endtask : boot_case

  task automatic decode_sweep();
    for (int i = 0; i < N; i++) begin
      bm.issue(ADR[i]);
      @(posedge clk);
      #1;
      chk_val(acc_ack_q, 32'h1);
      chk_tgt(acc_target_q, bsd_pkg::bsd_target_e'(TN[i]));
      chk_val(acc_reserved_q, TN[i] == 0);
    end
    bm.issue(ADR[50]);
    @(posedge clk);
    #1;
    chk_tgt(acc_target_q, bsd_pkg::TGT_DDR_CS0);
    bm.idle();
    @(posedge clk);
    #1;
    chk_val(acc_ack_q, 32'h0);
    chk_tgt(acc_target_q, bsd_pkg::TGT_DDR_CS0);
    chk_val(acc_reserved_q, 32'h0);
  endtask : decode_sweep

  initial begin
    fail_count = 0;
    n_checks = 0;
    rst_b = 1'b0;
    pins = 4'h0;
    host_done = 1'b0;
    loader_done = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    for (int c = 0; c < 16; c++) begin
      boot_case(c[3:0]);
    end
    decode_sweep();
    complete_run();
  end

  initial begin
    #(50 * 3000);
    fail_count++;
    complete_run();
  end

endmodule : boot_select_address_decode_tb
